// ---- hcm_maint_gate.sv ----
// maintenance interrupt source combination, registered
`timescale 1ns/1ps
module hcm_maint_gate
    import hcm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire hcm_ctrl_type i_ctrl,
    input wire logic i_vm_group1_enable,
    output logic o_maint_irq,
    output logic o_sources_active
);
    logic eoi_src; // unmatched eoi source
    logic g1d_src; // group 1 disabled source
    logic g1e_src; // group 1 enabled source
    logic any_src;

    // (R6) counter nonzero source
    assign eoi_src = (i_ctrl.unmatched_eoi_counter != '0) && i_ctrl.entry_missing_maint_enable;
    // (R7) group 1 disabled source
    assign g1d_src = i_ctrl.grp1_disabled_maint_enable && !i_vm_group1_enable;
    // (R8) group 1 enabled source
    assign g1e_src = i_ctrl.grp1_enabled_maint_enable && i_vm_group1_enable;
    assign any_src = eoi_src || g1d_src || g1e_src;

    // registered level output; one cycle behind the conditions
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_maint_irq <= 1'b0;
            o_sources_active <= 1'b0;
        end else begin
            // (R9) level, follows conditions
            // (R1) gated by global enable
            o_maint_irq <= any_src && i_ctrl.global_enable;
            o_sources_active <= any_src;
        end
    end
endmodule // hcm_maint_gate

// ---- hcm_pkg.sv ----
// package for the hypervisor control / maintenance block
package hcm_pkg;
    // register byte addresses
    localparam logic [11:0] HCM_ADDR_CTRL = 12'h000; // hypervisor_interface_control
    localparam logic [11:0] HCM_ADDR_STATUS = 12'h004; // block status, read only
    localparam logic [11:0] HCM_ADDR_ACK = 12'h008; // vm_acknowledge_read
    localparam logic [11:0] HCM_ADDR_VM = 12'h00c; // vm_group1_enable control
    // field positions of hypervisor_interface_control
    localparam int HCM_EOI_HI = 31;
    localparam int HCM_EOI_LO = 27;
    localparam int HCM_GRP1_DIS_BIT = 7;
    localparam int HCM_GRP1_EN_BIT = 6;
    localparam int HCM_ENTRY_MISS_BIT = 2;
    localparam int HCM_GLOBAL_EN_BIT = 0;
    // field widths and values
    localparam int HCM_EOI_W = 5;
    localparam logic [31:0] HCM_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] HCM_WRITABLE_MASK = 32'hf800_00c5;
    localparam logic [9:0] HCM_SPURIOUS_ID = 10'h3ff;
    // axi responses
    localparam logic [1:0] HCM_RESP_OKAY = 2'h0;
    localparam logic [1:0] HCM_RESP_SLVERR = 2'h2;

    // decoded control bits carried together
    typedef struct packed {
        logic [HCM_EOI_W-1:0] unmatched_eoi_counter;
        logic grp1_disabled_maint_enable;
        logic grp1_enabled_maint_enable;
        logic entry_missing_maint_enable;
        logic global_enable;
    } hcm_ctrl_type;

    // counter update: wraps from all ones to zero by natural overflow
    function automatic logic [HCM_EOI_W-1:0] hcm_inc(input logic [HCM_EOI_W-1:0] v);
        hcm_inc = v + 5'h01;
    endfunction
endpackage

// ---- hcm_top.sv ----
// hypervisor control register and maintenance logic with axi4-lite slave
// Contract
// (R1) no interrupts unless global enable set
// (R2) five-bit unmatched eoi count, bits 31:27
// (R3) hardware increments count on unmatched eoi
// (R4) eoi clearing no priority bit: no count
// (R5) count wraps from 31 to 0
// (R6) maint irq while count nonzero and enabled
// (R7) bit 7: signal while vm group1 off
// (R8) bit 6: signal while vm group1 on
// (R9) maintenance interrupt is level sensitive
// (R10) disabled: no irqs, acknowledge returns spurious
// (R11) entry-missing enable bit 2, global bit 0
// (R12) reserved bits 26:8 read zero, ignore writes
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module hcm_top
    import hcm_pkg::*;
#(
    parameter int ID_W = 10 // interrupt identifier width
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // axi4-lite write address
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    // axi4-lite write data
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // axi4-lite write response
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read address
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    // axi4-lite read data
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // eoi event from the virtual cpu interface, one-cycle pulse
    input wire logic i_eoi_unmatched,
    // that eoi cleared a bit in active_priorities_tracking
    input wire logic i_eoi_cleared_priority,
    // highest pending virtual interrupt from list logic
    input wire logic i_virq_pending,
    input wire logic [ID_W-1:0] i_virq_id,
    // gated outputs
    output logic o_maint_irq,
    output logic o_virq
);
    logic [31:0] ctrl_q; // hypervisor_interface_control storage
    logic vm_group1_enable; // held in its own register
    hcm_ctrl_type ctrl;
    logic sources_active;
    logic aw_held, w_held; // address/data already taken
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [31:0] next_rdata;
    logic rd_ok;

    assign ctrl.unmatched_eoi_counter = ctrl_q[HCM_EOI_HI:HCM_EOI_LO];
    assign ctrl.grp1_disabled_maint_enable = ctrl_q[HCM_GRP1_DIS_BIT];
    assign ctrl.grp1_enabled_maint_enable = ctrl_q[HCM_GRP1_EN_BIT];
    // (R11) enable bit positions
    assign ctrl.entry_missing_maint_enable = ctrl_q[HCM_ENTRY_MISS_BIT];
    assign ctrl.global_enable = ctrl_q[HCM_GLOBAL_EN_BIT];

    // byte-lane merge used by the control register write only
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        merge = r;
    endfunction

    // write fires once both address and data are in hand and no response waits
    assign do_write = aw_held && w_held && !o_bvalid;

    // write address capture; ready high while slot empty and no response waits
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            o_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            o_awready <= 1'b0;
        end else if (o_awready && i_awvalid) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
            o_awready <= 1'b0;
        end else begin
            o_awready <= !aw_held && !o_bvalid;
        end
    end

    // write data capture, independent of address order
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            o_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
            o_wready <= 1'b0;
        end else if (o_wready && i_wvalid) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
            o_wready <= 1'b0;
        end else begin
            o_wready <= !w_held && !o_bvalid;
        end
    end

    // write response; unmapped or read-only addresses answer slverr
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= HCM_RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= (aw_addr == HCM_ADDR_CTRL || aw_addr == HCM_ADDR_VM)
                       ? HCM_RESP_OKAY : HCM_RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // control register: software write and hardware count in one process
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_q <= HCM_CTRL_RESET;
        end else begin
            logic [31:0] v;
            v = ctrl_q;
            if (do_write && aw_addr == HCM_ADDR_CTRL) begin
                // (R12) reserved bits stay zero
                v = merge(ctrl_q, w_data, w_strb) & HCM_WRITABLE_MASK;
            end
            // a same-cycle hardware event increments the software-written count
            // (R3) automatic count of unmatched eoi
            // (R4) only priority-clearing eois count
            if (i_eoi_unmatched && i_eoi_cleared_priority) begin
                // (R2) count field bits 31:27
                // (R5) wraps 31 to 0
                v[HCM_EOI_HI:HCM_EOI_LO] = hcm_inc(v[HCM_EOI_HI:HCM_EOI_LO]);
            end
            ctrl_q <= v;
        end
    end

    // vm group 1 enable, modelled as a software register here
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            vm_group1_enable <= 1'b0;
        end else if (do_write && aw_addr == HCM_ADDR_VM && w_strb[0]) begin
            vm_group1_enable <= w_data[0];
        end
    end

    // read data mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_ok = 1'b1;
        case (i_araddr)
            HCM_ADDR_CTRL: next_rdata = ctrl_q;
            HCM_ADDR_STATUS: next_rdata = {29'h0, vm_group1_enable, sources_active,
                                           o_maint_irq};
            // (R10) spurious id while disabled
            HCM_ADDR_ACK: next_rdata = (ctrl.global_enable && i_virq_pending)
                                       ? {{(32-ID_W){1'b0}}, i_virq_id}
                                       : {22'h0, HCM_SPURIOUS_ID};
            HCM_ADDR_VM: next_rdata = {31'h0, vm_group1_enable};
            default: rd_ok = 1'b0;
        endcase
    end

    // read channel: one read at a time, answer the cycle after acceptance
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= HCM_RESP_OKAY;
        end else if (o_arready && i_arvalid) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= next_rdata;
            o_rresp <= rd_ok ? HCM_RESP_OKAY : HCM_RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end else begin
            o_arready <= !o_rvalid;
        end
    end

    // (R10) virtual interrupt gated by global enable
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_virq <= 1'b0;
        end else begin
            // (R1) global enable gate
            o_virq <= i_virq_pending && ctrl.global_enable;
        end
    end

    // maintenance source combination
    hcm_maint_gate u_gate (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ctrl(ctrl),
        .i_vm_group1_enable(vm_group1_enable),
        .o_maint_irq(o_maint_irq),
        .o_sources_active(sources_active)
    );
endmodule // hcm_top

// ---- hcm_top_monitor.sv ----
// port-level checker for the hypervisor control block
`timescale 1ns/1ps
module hcm_top_monitor
    import hcm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_eoi_unmatched,
    input wire logic i_eoi_cleared_priority,
    input wire logic i_virq_pending,
    input wire logic o_maint_irq,
    input wire logic o_virq
);
    // only a register write or a counted eoi may move the irq level
    logic cause;
    assign cause = o_bvalid || (i_eoi_unmatched && i_eoi_cleared_priority);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    a_quiet_after_reset: assert property ($fell(i_sys_rst) |-> !o_maint_irq && !o_virq)
        else $error("interrupt right after reset");
    a_virq_gated: assert property (o_virq |-> $past(i_virq_pending))
        else $error("virtual irq without pending input");
    a_maint_level_cause: assert property ($changed(o_maint_irq) |->
        $past(cause) || $past(cause, 2) || $past(i_sys_rst))
        else $error("maintenance irq moved without cause");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |-> ##[1:3] o_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (i_arvalid && o_arready |-> ##[1:3] o_rvalid)
        else $error("read not answered");
    a_busy_refuse: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted while response waits");
    c_irq_on: cover property ($rose(o_maint_irq));
    c_irq_off: cover property ($fell(o_maint_irq));
    c_slverr: cover property (o_bvalid && o_bresp == HCM_RESP_SLVERR);
endmodule // hcm_top_monitor

bind hcm_top hcm_top_monitor u_mon (.i_clk, .i_sys_rst, .i_awvalid, .o_awready, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
    .i_rready, .i_eoi_unmatched, .i_eoi_cleared_priority, .i_virq_pending, .o_maint_irq,
    .o_virq);

// ---- tb_hcm_top.sv ----
// self-checking bench for the hypervisor control block
`timescale 1ns/1ps
module tb_hcm_top
    import hcm_pkg::*;
;
    // one row: vm group1 level, control write, expected readback and irq
    typedef struct packed {logic vm; logic [31:0] wr; logic [31:0] rd; logic irq;} hcm_row_type;
    hcm_row_type rows [9] = '{'{1'b0, 32'h81, 32'h81, 1'b1}, '{1'b0, 32'h80, 32'h80, 1'b0},
        '{1'b1, 32'h41, 32'h41, 1'b1}, '{1'b0, 32'h41, 32'h41, 1'b0},
        '{1'b1, 32'h81, 32'h81, 1'b0}, '{1'b0, 32'h0800_0005, 32'h0800_0005, 1'b1},
        '{1'b0, 32'h0800_0001, 32'h0800_0001, 1'b0},
        '{1'b1, 32'hffff_ffff, 32'hf800_00c5, 1'b1}, '{1'b1, 32'h0, 32'h0, 1'b0}};
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_eoi_unmatched = 1'b0;
    logic i_eoi_cleared_priority = 1'b0, i_virq_pending = 1'b1;
    logic [11:0] i_awaddr = '0, i_araddr = '0;
    logic [31:0] i_wdata = '0, o_rdata;
    logic [3:0] i_wstrb = 4'hf;
    logic [9:0] i_virq_id = 10'h155; // arbitrary pending id
    logic [1:0] o_bresp, o_rresp;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_maint_irq, o_virq;
    int num_errors = 0;
    int compares = 0;
    hcm_top u_dut (.i_clk, .i_sys_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_eoi_unmatched,
        .i_eoi_cleared_priority, .i_virq_pending, .i_virq_id, .o_maint_irq, .o_virq);
    // 100 ns period
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one edge; a wait that runs too long ends the run as a failure
    task automatic tick(inout int n);
        @(posedge i_clk);
        n++;
        if (n > 60) begin
            num_errors++;
            finish_test();
        end
    endtask
    // write: address and data offered together, response taken late to test its hold
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        logic aw;
        logic w;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        do begin
            tick(n);
            if (o_awready) aw = 1'b0;
            if (o_wready) w = 1'b0;
            i_awvalid <= aw;
            i_wvalid <= w;
        end while (aw || w);
        do tick(n); while (o_bvalid !== 1'b1);
        // ready raised only now, so the response must hold for an extra cycle
        i_bready <= 1'b1;
        tick(n);
        // response taken at the handshake edge
        chk("bresp", e, o_bresp);
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do tick(n); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do tick(n); while (o_rvalid !== 1'b1);
        i_rready <= 1'b1;
        tick(n);
        // data and response taken at the handshake edge
        chk("rdata", e, o_rdata);
        chk("rresp", er, o_rresp);
        i_rready <= 1'b0;
    endtask
    // one-cycle eoi pulse, qualified or not
    task automatic eoi(input logic q);
        i_eoi_unmatched <= 1'b1;
        i_eoi_cleared_priority <= q;
        @(posedge i_clk);
        i_eoi_unmatched <= 1'b0;
        i_eoi_cleared_priority <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        rd(HCM_ADDR_CTRL, HCM_CTRL_RESET, HCM_RESP_OKAY);
        foreach (rows[k]) begin
            wr(HCM_ADDR_VM, {31'h0, rows[k].vm}, HCM_RESP_OKAY);
            wr(HCM_ADDR_CTRL, rows[k].wr, HCM_RESP_OKAY);
            repeat (3) @(posedge i_clk);
            rd(HCM_ADDR_CTRL, rows[k].rd, HCM_RESP_OKAY);
            chk("maint", rows[k].irq, o_maint_irq);
            chk("virq", rows[k].rd[0], o_virq);
            rd(HCM_ADDR_ACK, rows[k].rd[0] ? 32'h155 : 32'h3ff, HCM_RESP_OKAY);
        end
        // counting, qualification and wrap, starting from thirty
        wr(HCM_ADDR_CTRL, 32'hf000_0005, HCM_RESP_OKAY);
        eoi(1'b0);
        rd(HCM_ADDR_CTRL, 32'hf000_0005, HCM_RESP_OKAY);
        eoi(1'b1);
        rd(HCM_ADDR_CTRL, 32'hf800_0005, HCM_RESP_OKAY);
        eoi(1'b1);
        rd(HCM_ADDR_CTRL, 32'h0000_0005, HCM_RESP_OKAY);
        chk("maint", 0, o_maint_irq);
        eoi(1'b1);
        eoi(1'b1);
        rd(HCM_ADDR_CTRL, 32'h1000_0005, HCM_RESP_OKAY);
        chk("maint", 1, o_maint_irq);
        // nothing pending while enabled: no virtual irq, acknowledge reads spurious
        i_virq_pending <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("virq", 0, o_virq);
        rd(HCM_ADDR_ACK, {22'h0, HCM_SPURIOUS_ID}, HCM_RESP_OKAY);
        i_virq_pending <= 1'b1;
        // lane 0 only: the count in lane 3 survives, reserved bits stay zero
        i_wstrb <= 4'h1;
        wr(HCM_ADDR_CTRL, 32'hffff_ffff, HCM_RESP_OKAY);
        i_wstrb <= 4'hf;
        rd(HCM_ADDR_CTRL, 32'h1000_00c5, HCM_RESP_OKAY);
        wr(HCM_ADDR_CTRL, 32'h1000_0004, HCM_RESP_OKAY);
        repeat (3) @(posedge i_clk);
        chk("maint", 0, o_maint_irq);
        // disabled: the ungated source still shows in status, the irq does not
        rd(HCM_ADDR_STATUS, 32'h0000_0006, HCM_RESP_OKAY);
        // refused accesses
        rd(12'h010, 32'h0, HCM_RESP_SLVERR);
        wr(12'h010, 32'h1, HCM_RESP_SLVERR);
        wr(HCM_ADDR_STATUS, 32'h1, HCM_RESP_SLVERR);
        // reset in mid-run clears the control word
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        rd(HCM_ADDR_CTRL, HCM_CTRL_RESET, HCM_RESP_OKAY);
        chk("maint", 0, o_maint_irq);
        finish_test();
    end
endmodule // tb_hcm_top
